// >>> src/tim_irq_arbiter.sv
// Fixed priority pick among pending timer interrupt sources
`timescale 1ns/1ps
module tim_irq_arbiter #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] pending_in,
	output logic any_out,
	output logic [2:0] idx_out
);
	import tim_pkg::*;

	// Higher bit wins: it owns the lower vector address
	always_comb
	begin
		any_out = 1'b0;
		idx_out = TIM_IDX_RST;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (pending_in[i])
			begin
				any_out = 1'b1;
				idx_out = i[2:0];
			end
		end
	end

endmodule

// >>> src/tim_irq_unit.sv
// Timer interrupt flag, mask and global enable unit with vector request to the core
// Summary of operation
// - Compare A request at vector 0018 needs mask bit 4 and global enable.
// - Compare B request at vector 001A needs mask bit 3 and global enable.
// - Counter 1 overflow request at 001C needs mask bit 2 and global enable.
// - Counter 0 compare request at 001E needs mask bit 1 and global enable.
// - Counter 0 overflow request at 0020 needs mask bit 0 and global enable.
// - Counter 2 compare match sets flag bit 7.
// - Counter 2 overflow sets flag bit 6.
// - Counter 2 in PWM sets bit 6 on direction turn at zero, not wrap.
// - Input capture sets flag bit 5.
// - Counter 1 compare A match sets flag bit 4.
// - Counter 1 compare B match sets flag bit 3.
// - Counter 1 overflow in normal counting sets flag bit 2.
// - Counter 1 in PWM sets overflow flag on direction turn at zero.
// - Counter 0 compare match sets flag bit 1.
// - Counter 0 overflow sets flag bit 0.
// - Taking a vector clears the flag belonging to it.
// - Writing one to a flag clears it; zero leaves it alone.
// - Request only while global enable, mask bit and flag are all one.
// - Eight readable flags, reset to zero, in the fixed bit order.
// - Mask bits 7, 6, 5 enable vectors 0012, 0014 and 0016.
// - Taking any vector clears global enable; return sets it again.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module tim_irq_unit #(
	parameter int NUM_SRC = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire tim_pkg::tim_match_t match_in,
	input wire tim_pkg::tim_ovf_src_t ovf_src_in,
	input wire logic vector_taken_in,
	input wire logic reti_in,
	output logic irq_req_out,
	output logic [15:0] irq_vector_out,
	output logic [2:0] irq_idx_out,
	output logic gie_out
);
	import tim_pkg::*;

	// ****************************************
	// State
	// ****************************************
	logic [7:0] timer_event_flags;
	logic [7:0] timer_irq_enable_mask;
	logic gie;
	logic [7:0] next_flags;
	logic [7:0] next_mask;
	logic next_gie;
	logic [7:0] set_vec;
	logic [7:0] sw_clr;
	logic [7:0] hw_clr;
	logic [7:0] next_pending;
	logic next_any;
	logic [2:0] next_idx;
	logic taken;
	logic wr_flags;
	logic wr_mask;
	logic wr_status;

	assign wr_flags = reg_wr_in && (reg_addr_in == TIM_FLAGS_OFS);
	assign wr_mask = reg_wr_in && (reg_addr_in == TIM_MASK_OFS);
	assign wr_status = reg_wr_in && (reg_addr_in == TIM_STATUS_OFS);
	// An acknowledge without a standing request has nothing to clear
	assign taken = vector_taken_in && irq_req_out;

	// ****************************************
	// Event collection
	// ****************************************
	always_comb
	begin
		set_vec = 8'h00;
		set_vec[TIM_BIT_CNT2_CMP] = match_in.cnt2_cmp;
		set_vec[TIM_BIT_CNT2_OVF] = ovf_src_in.cnt2_pwm ? ovf_src_in.cnt2_turn
			: ovf_src_in.cnt2_wrap;
		set_vec[TIM_BIT_CNT1_CAP] = match_in.cnt1_capture;
		set_vec[TIM_BIT_CNT1_CMP_A] = match_in.cnt1_cmp_a;
		set_vec[TIM_BIT_CNT1_CMP_B] = match_in.cnt1_cmp_b;
		set_vec[TIM_BIT_CNT1_OVF] = ovf_src_in.cnt1_pwm ? ovf_src_in.cnt1_turn
			: ovf_src_in.cnt1_wrap;
		set_vec[TIM_BIT_CNT0_CMP] = match_in.cnt0_cmp;
		set_vec[TIM_BIT_CNT0_OVF] = match_in.cnt0_ovf;
	end

	// ****************************************
	// Next register values
	// ****************************************
	always_comb
	begin
		sw_clr = wr_flags ? reg_wdata_in : 8'h00;
		// clear the flag of the taken vector
		hw_clr = 8'h00;
		if (taken)
		begin
			hw_clr[irq_idx_out] = 1'b1;
		end
		next_flags = (timer_event_flags & ~(sw_clr | hw_clr)) | set_vec;
		next_mask = wr_mask ? reg_wdata_in : timer_irq_enable_mask;
		// taken clears, return sets, software write loads data bit 7
		if (taken)
		begin
			next_gie = 1'b0;
		end
		else if (reti_in)
		begin
			next_gie = 1'b1;
		end
		else if (wr_status)
		begin
			next_gie = reg_wdata_in[TIM_GIE_BIT];
		end
		else
		begin
			next_gie = gie;
		end
		// flag, mask and global enable all needed
		next_pending = next_flags & next_mask & {8{next_gie}};
	end

	tim_irq_arbiter #(
		.WIDTH(NUM_SRC)
	) u_arbiter (
		.pending_in(next_pending),
		.any_out(next_any),
		.idx_out(next_idx)
	);

	// ****************************************
	// Flag register
	// ****************************************
	// flags reset to zero
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			timer_event_flags <= TIM_FLAGS_RST;
		end
		else
		begin
			timer_event_flags <= next_flags;
		end
	end

	// ****************************************
	// Mask and global enable
	// ****************************************
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			timer_irq_enable_mask <= TIM_MASK_RST;
			gie <= TIM_GIE_RST;
		end
		else
		begin
			timer_irq_enable_mask <= next_mask;
			gie <= next_gie;
		end
	end

	// ****************************************
	// Request to the core
	// ****************************************
	// Built from next values so the request mirrors the registers with no lag
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			irq_req_out <= 1'b0;
			irq_idx_out <= TIM_IDX_RST;
			irq_vector_out <= TIM_VEC_RST;
			gie_out <= TIM_GIE_RST;
		end
		else
		begin
			irq_req_out <= next_any;
			irq_idx_out <= next_idx;
			irq_vector_out <= next_any ? tim_vec_addr(next_idx) : TIM_VEC_RST;
			gie_out <= next_gie;
		end
	end

	// ****************************************
	// Register read port
	// ****************************************
	// flags readable
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			reg_rdata_out <= TIM_RDATA_RST;
		end
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				TIM_FLAGS_OFS: reg_rdata_out <= timer_event_flags;
				TIM_MASK_OFS: reg_rdata_out <= timer_irq_enable_mask;
				TIM_STATUS_OFS: reg_rdata_out <= {gie, 7'h00};
				default: reg_rdata_out <= TIM_RDATA_RST;
			endcase
		end
		else
		begin
			// Data stand only in the cycle after the read
			reg_rdata_out <= TIM_RDATA_RST;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	logic [7:0] pend_now;
	assign pend_now = timer_event_flags & timer_irq_enable_mask & {8{gie}};

	sequence s_read_flags;
		reg_rd_in && (reg_addr_in == TIM_FLAGS_OFS);
	endsequence

	sequence s_take;
		vector_taken_in && irq_req_out;
	endsequence

	a_event_sets_flag: assert property (
		(|set_vec) |=> ((timer_event_flags & $past(set_vec)) == $past(set_vec)))
		else $error("event did not set its flag");

	a_write_one_clear: assert property (
		(wr_flags && !taken && (set_vec == 8'h00))
		|=> (timer_event_flags == ($past(timer_event_flags) & ~$past(reg_wdata_in))))
		else $error("write one clear wrong");

	a_taken_clears_flag: assert property (
		(s_take and (!set_vec[irq_idx_out])) |=> !timer_event_flags[$past(irq_idx_out)])
		else $error("taken vector left its flag set");

	a_taken_drops_gie: assert property (
		s_take |=> (!gie_out && !irq_req_out))
		else $error("global enable survived a taken vector");

	a_return_sets_gie: assert property (
		(reti_in && !taken) |=> gie_out)
		else $error("return did not restore global enable");

	a_req_gated: assert property (
		irq_req_out == (|pend_now))
		else $error("request not gated by flag, mask and enable");

	a_lowest_vector: assert property (
		irq_req_out |-> (pend_now[irq_idx_out]
		&& ((pend_now >> irq_idx_out) == 8'h01)
		&& (irq_vector_out == tim_vec_addr(irq_idx_out))))
		else $error("presented vector is not the lowest pending");

	a_read_flags: assert property (
		s_read_flags |=> (reg_rdata_out == $past(timer_event_flags)))
		else $error("flag read data wrong");

	a_pwm_turn_ovf: assert property (
		(ovf_src_in.cnt1_pwm && ovf_src_in.cnt1_turn) |=> timer_event_flags[TIM_BIT_CNT1_OVF])
		else $error("PWM turn did not set counter 1 overflow flag");

	a_pwm_no_wrap: assert property (
		(ovf_src_in.cnt2_pwm && ovf_src_in.cnt2_wrap && !ovf_src_in.cnt2_turn
		&& !timer_event_flags[TIM_BIT_CNT2_OVF]) |=> !timer_event_flags[TIM_BIT_CNT2_OVF])
		else $error("wrap set counter 2 overflow flag in PWM");

	sequence s_write_mask;
		reg_wr_in && (reg_addr_in == TIM_MASK_OFS);
	endsequence

	sequence s_write_status;
		wr_status && !taken && !reti_in;
	endsequence

	sequence s_stray_take;
		vector_taken_in && !irq_req_out;
	endsequence

	a_mask_write: assert property (
		s_write_mask |=> (timer_irq_enable_mask == $past(reg_wdata_in)))
		else $error("mask write did not land");

	a_status_write: assert property (
		s_write_status |=> (gie_out == $past(reg_wdata_in[TIM_GIE_BIT])))
		else $error("status write did not set global enable");

	a_stray_take: assert property (
		(s_stray_take and (!reti_in && !wr_status && !wr_flags))
		|=> ((gie_out == $past(gie))
		&& (($past(timer_event_flags) & ~timer_event_flags) == 8'h00)))
		else $error("acknowledge without request changed state");

	a_flag_holds: assert property (
		(timer_event_flags != 8'h00)
		|=> ((($past(timer_event_flags) & ~timer_event_flags)
		& ~($past(sw_clr) | $past(hw_clr))) == 8'h00))
		else $error("flag dropped with no clear");

	a_rdata_idle: assert property (
		!reg_rd_in |=> (reg_rdata_out == TIM_RDATA_RST))
		else $error("read data stood outside the read cycle");

	a_idle_outputs: assert property (
		!irq_req_out
		|-> ((irq_vector_out == TIM_VEC_RST) && (irq_idx_out == TIM_IDX_RST)))
		else $error("vector or index shown with no request");

	a_gie_mirror: assert property (
		gie_out == gie)
		else $error("global enable output differs from its register");

	a_cnt2_wrap: assert property (
		(!ovf_src_in.cnt2_pwm && ovf_src_in.cnt2_wrap)
		|=> timer_event_flags[TIM_BIT_CNT2_OVF])
		else $error("wrap did not set counter 2 overflow flag");

	a_cnt1_wrap: assert property (
		(!ovf_src_in.cnt1_pwm && ovf_src_in.cnt1_wrap)
		|=> timer_event_flags[TIM_BIT_CNT1_OVF])
		else $error("wrap did not set counter 1 overflow flag");

	a_cnt1_no_wrap: assert property (
		(ovf_src_in.cnt1_pwm && ovf_src_in.cnt1_wrap && !ovf_src_in.cnt1_turn
		&& !timer_event_flags[TIM_BIT_CNT1_OVF]) |=> !timer_event_flags[TIM_BIT_CNT1_OVF])
		else $error("wrap set counter 1 overflow flag in PWM");

	a_cnt2_turn: assert property (
		(ovf_src_in.cnt2_pwm && ovf_src_in.cnt2_turn)
		|=> timer_event_flags[TIM_BIT_CNT2_OVF])
		else $error("PWM turn did not set counter 2 overflow flag");

endmodule

// >>> src/tim_pkg.sv
// Constants, types and helpers shared by the timer interrupt flag and mask unit
package tim_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] TIM_FLAGS_OFS = 8'h36;
	localparam logic [7:0] TIM_MASK_OFS = 8'h37;
	localparam logic [7:0] TIM_STATUS_OFS = 8'h3F;
	localparam int TIM_GIE_BIT = 7;

	localparam logic [7:0] TIM_FLAGS_RST = 8'h00;
	localparam logic [7:0] TIM_MASK_RST = 8'h00;
	localparam logic TIM_GIE_RST = 1'b0;
	localparam logic [7:0] TIM_RDATA_RST = 8'h00;

	// ****************************************
	// Flag and mask bit positions
	// ****************************************
	localparam int TIM_BIT_CNT2_CMP = 7;
	localparam int TIM_BIT_CNT2_OVF = 6;
	localparam int TIM_BIT_CNT1_CAP = 5;
	localparam int TIM_BIT_CNT1_CMP_A = 4;
	localparam int TIM_BIT_CNT1_CMP_B = 3;
	localparam int TIM_BIT_CNT1_OVF = 2;
	localparam int TIM_BIT_CNT0_CMP = 1;
	localparam int TIM_BIT_CNT0_OVF = 0;

	// ****************************************
	// Vector table
	// ****************************************
	localparam logic [15:0] TIM_VEC_BASE = 16'h0012;
	localparam logic [15:0] TIM_VEC_RST = 16'h0000;
	localparam logic [2:0] TIM_IDX_RST = 3'h0;
	localparam logic [2:0] TIM_IDX_TOP = 3'h7;

	// ****************************************
	// Event carriers
	// ****************************************
	typedef struct packed {
		logic cnt2_cmp;
		logic cnt1_capture;
		logic cnt1_cmp_a;
		logic cnt1_cmp_b;
		logic cnt0_cmp;
		logic cnt0_ovf;
	} tim_match_t;

	typedef struct packed {
		logic cnt2_pwm;
		logic cnt2_wrap;
		logic cnt2_turn;
		logic cnt1_pwm;
		logic cnt1_wrap;
		logic cnt1_turn;
	} tim_ovf_src_t;

	// Bit 7 has the lowest vector, each lower bit is one word further on
	function automatic logic [15:0] tim_vec_addr(input logic [2:0] idx);
		tim_vec_addr = TIM_VEC_BASE + {12'h000, TIM_IDX_TOP - idx, 1'b0};
	endfunction

endpackage

// >>> tb/test_tim_irq_unit.sv
// Random self-checking bench for the timer interrupt flag and mask unit
`timescale 1ns/1ps
module test_tim_irq_unit;
	import tim_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	tim_match_t match_in = '0;
	tim_ovf_src_t ovf_src_in = '0;
	logic slow = 1'b0;
	logic [7:0] reg_rdata_out;
	logic vector_taken_in, reti_in, irq_req_out, gie_out;
	logic [15:0] irq_vector_out;
	logic [2:0] irq_idx_out;
	logic [31:0] seed = 32'h0000708B;
	logic [7:0] addr_tab [4] = '{TIM_FLAGS_OFS, TIM_MASK_OFS, TIM_STATUS_OFS, 8'h55};
	int n_fail = 0;
	int checks_done = 0;
	int cycles = 0;
	int m_flags, m_mask, m_gie, m_rdata, m_req, m_idx;

	tim_irq_unit u_tim_irq_unit (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .match_in(match_in),
		.ovf_src_in(ovf_src_in), .vector_taken_in(vector_taken_in), .reti_in(reti_in),
		.irq_req_out(irq_req_out), .irq_vector_out(irq_vector_out),
		.irq_idx_out(irq_idx_out), .gie_out(gie_out));
	tim_core_model u_tim_core_model (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.irq_req_in(irq_req_out), .slow_in(slow), .vector_taken_out(vector_taken_in),
		.reti_out(reti_in));

	initial
	begin
		forever #2 ref_clk_in = ~ref_clk_in;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		xs = v ^ (v << 5);
	endfunction

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ****
	// Reference model
	// ****
	always @(posedge ref_clk_in)
	begin
		logic [7:0] s;
		int clr;
		m_rdata = 0;
		if (rst_in)
		begin
			m_flags = 0;
			m_mask = 0;
			m_gie = 0;
		end
		else
		begin
			if (reg_rd_in && reg_addr_in == TIM_FLAGS_OFS)
				m_rdata = m_flags;
			if (reg_rd_in && reg_addr_in == TIM_MASK_OFS)
				m_rdata = m_mask;
			if (reg_rd_in && reg_addr_in == TIM_STATUS_OFS)
				m_rdata = m_gie << 7;
			s[7] = match_in.cnt2_cmp;
			s[6] = ovf_src_in.cnt2_pwm ? ovf_src_in.cnt2_turn : ovf_src_in.cnt2_wrap;
			s[5] = match_in.cnt1_capture;
			s[4] = match_in.cnt1_cmp_a;
			s[3] = match_in.cnt1_cmp_b;
			s[2] = ovf_src_in.cnt1_pwm ? ovf_src_in.cnt1_turn : ovf_src_in.cnt1_wrap;
			s[1] = match_in.cnt0_cmp;
			s[0] = match_in.cnt0_ovf;
			clr = 0;
			if (reg_wr_in && reg_addr_in == TIM_FLAGS_OFS)
				clr = reg_wdata_in;
			if (vector_taken_in && m_req != 0)
				clr = clr | (1 << m_idx);
			m_flags = (m_flags & ~clr) | s;
			if (reg_wr_in && reg_addr_in == TIM_MASK_OFS)
				m_mask = reg_wdata_in;
			if (vector_taken_in && m_req != 0)
				m_gie = 0;
			else if (reti_in)
				m_gie = 1;
			else if (reg_wr_in && reg_addr_in == TIM_STATUS_OFS)
				m_gie = reg_wdata_in[7];
		end
		m_req = (m_flags & m_mask) != 0 && m_gie != 0;
		m_idx = 0;
		for (int i = 0; i < 8; i++)
			if ((m_flags & m_mask) & (1 << i))
				m_idx = i;
	end

	always @(negedge ref_clk_in)
	begin
		check("irq_req", 16'(irq_req_out), 16'(m_req));
		check("irq_vector", irq_vector_out, m_req ? TIM_VEC_BASE + 16'(2 * (7 - m_idx)) : 16'h0000);
		check("irq_idx", 16'(irq_idx_out), m_req ? 16'(m_idx) : 16'h0000);
		check("gie", 16'(gie_out), 16'(m_gie));
		check("rdata", 16'(reg_rdata_out), 16'(m_rdata));
	end

	always @(posedge ref_clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			end_of_test();
		end
	end

	// ****
	// Stimulus
	// ****
	task automatic drive(input bit quiet);
		logic [31:0] a;
		logic [31:0] b;
		seed = xs(seed);
		a = seed;
		seed = xs(seed);
		b = seed;
		reg_wr_in <= !quiet && a[2:0] == 3'h0;
		reg_rd_in <= !quiet && (a[2:0] == 3'h1 || a[2:0] == 3'h2);
		reg_addr_in <= addr_tab[a[4:3]];
		reg_wdata_in <= a[12:5];
		match_in <= quiet ? '0 : tim_match_t'(a[18:13] & a[24:19] & b[5:0]);
		ovf_src_in <= quiet ? '0 : tim_ovf_src_t'(b[11:6] & (b[17:12] | 6'h24));
	endtask

	initial
	begin
		repeat (6) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 3000; i++)
		begin
			@(posedge ref_clk_in);
			rst_in <= (i >= 1500 && i < 1504);
			slow <= i[9];
			drive(i >= 1499 && i <= 1505);
		end
		end_of_test();
	end
endmodule

// >>> tb/tim_core_model.sv
// Behavioural core sequencer that takes vectors and returns from handlers
`timescale 1ns/1ps
module tim_core_model (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic irq_req_in,
	input wire logic slow_in,
	output logic vector_taken_out = 1'b0,
	output logic reti_out = 1'b0
);
	int cnt = 0;
	logic in_isr = 1'b0;

	// One spare cycle before serving, as after a return, or nine while slow_in is set
	always @(posedge ref_clk_in)
	begin
		vector_taken_out <= 1'b0;
		reti_out <= 1'b0;
		cnt <= cnt + 1;
		if (rst_in)
		begin
			cnt <= 0;
			in_isr <= 1'b0;
		end
		else if (!in_isr && irq_req_in && cnt >= (slow_in ? 9 : 1))
		begin
			vector_taken_out <= 1'b1;
			in_isr <= 1'b1;
			cnt <= 0;
		end
		else if (in_isr && cnt >= (slow_in ? 12 : 3))
		begin
			reti_out <= 1'b1;
			in_isr <= 1'b0;
			cnt <= 0;
		end
	end
endmodule
